// ### testbench/mtpc_pins_model.sv
// Purpose: pin-side model driving the timer inputs
// Assumes: square wave of half period half while run is high
// Notes: all lines rest low between bursts
`timescale 1ns/1ps
`default_nettype none
module mtpc_pins_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic [7:0] half,
    output logic            cap_a,
    output logic            gate_a,
    output logic            cap_b
);
    logic [7:0] ph;   // Cycles into this half period
    logic       wave; // Shared input waveform
    // Toggle every half cycles, rest low when idle
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            ph   <= 8'h00;
            wave <= 1'b0;
        end else if (ph == half - 8'h01) begin
            ph   <= 8'h00;
            wave <= ~wave;
        end else begin
            ph <= ph + 8'h01;
        end
    end
    assign cap_a  = wave;
    assign gate_a = wave;
    assign cap_b  = wave;
endmodule : mtpc_pins_model
`default_nettype wire

// ### testbench/mtpc_top_assertions.sv
// Purpose: port checker for mtpc_top
// Assumes: timer 0 pulse checks use rise 2, fall 4, prescale 0
// Notes: bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
`include "mtpc_map.svh"
module mtpc_top_assertions
    import mtpc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire mtpc_cfg_t  cfg [`MTPC_NUM_TIMERS],
    input  wire mtpc_stat_t stat [`MTPC_NUM_TIMERS],
    input  wire logic       timer_a_waveform_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Start of the fixed timer 0 pulse
    sequence s_go;
        cfg[0].start && !cfg[0].stop && cfg[0].enable && cfg[0].mode == MTPC_MODE_TIMER
            && cfg[0].prescale == 5'h00 && cfg[0].rise_count == 16'h0002
            && cfg[0].fall_count == 16'h0004;
    endsequence
    // Rise three ticks on, fall three later
    sequence s_cycle;
        ##3 stat[0].rise_event ##3 stat[0].fall_event;
    endsequence
    property p_cycle; s_go ##0 (cfg[0].irq_rise_en && cfg[0].irq_fall_en) |-> s_cycle; endproperty
    a_cycle: assert property (p_cycle) else $error("pulse edges off");
    property p_run; s_go |-> ##2 stat[0].running; endproperty
    a_run: assert property (p_run) else $error("start not taken");
    property p_pin; stat[0].rise_event && cfg[0].out_en && !cfg[0].invert |=> timer_a_waveform_out;
    endproperty
    a_pin: assert property (p_pin) else $error("pin not high after rise");
    property p_low; stat[0].fall_event && cfg[0].out_en && !cfg[0].invert |=> !timer_a_waveform_out;
    endproperty
    a_low: assert property (p_low) else $error("pin not low after fall");
    property p_single;
        stat[0].fall_event && !cfg[0].repeat_run && !cfg[0].start |-> ##[1:2] !stat[0].running;
    endproperty
    a_single: assert property (p_single) else $error("single shot kept running");
    property p_rep;
        stat[0].fall_event && cfg[0].repeat_run && cfg[0].prescale == 5'h00
            && cfg[0].mode == MTPC_MODE_TIMER
            && cfg[0].fall_count == 16'h0004 ##1 (!cfg[0].stop && !cfg[0].start)[*4]
            |=> stat[0].fall_event;
    endproperty
    a_rep: assert property (p_rep) else $error("repeat period wrong");
    property p_pulse; stat[0].rise_event |=> !stat[0].rise_event; endproperty
    a_pulse: assert property (p_pulse) else $error("event longer than a cycle");
    property p_gate;
        !$past(cfg[0].irq_rise_en) && !cfg[0].irq_rise_en |-> !stat[0].rise_event;
    endproperty
    a_gate: assert property (p_gate) else $error("masked rise event seen");
    property p_refuse;
        cfg[2].start && cfg[2].mode inside {MTPC_MODE_COUNTER, MTPC_MODE_CAPTURE}
            && !stat[2].running |=> !stat[2].running [*3];
    endproperty
    a_refuse: assert property (p_refuse) else $error("pin-less mode accepted");
    property p_stop; cfg[0].stop && !cfg[0].start |-> ##2 !stat[0].running; endproperty
    a_stop: assert property (p_stop) else $error("stop ignored");
endmodule : mtpc_top_assertions
`default_nettype wire

// ### testbench/mtpc_top_tb_top.sv
// Purpose: self-checking bench for mtpc_top
// Assumes: inputs come from mtpc_pins_model
// Notes: timer 0 edge events checked against a queue of gaps
`timescale 1ns/1ps
`default_nettype none
`include "mtpc_map.svh"
module mtpc_top_tb_top
    import mtpc_pkg::*;
();
    logic       clk = 1'b0;                 // Bench clock
    logic       rst = 1'b1;                 // Bench reset
    mtpc_cfg_t  cfg [`MTPC_NUM_TIMERS];     // Timer settings
    mtpc_stat_t stat [`MTPC_NUM_TIMERS];    // Timer status
    mtpc_cfg_t  c;                          // Scratch setting
    logic       cap_a, gate_a, cap_b, run;  // Pin side
    logic [7:0] half, pins;                 // Wave half period, outputs
    logic [15:0] r1, f1;                    // Capture stamps
    int         num_errors = 0, check_count = 0, cyc = 0, ref_c = 0, e, k, h, watch = 0;
    int         exp_q [$];                  // Gap times two plus edge kind
    mtpc_top u_dut (.clk(clk), .rst(rst), .cfg(cfg), .timer_a_capture_in(cap_a),
        .timer_a_clock_gate_in(gate_a), .timer_b_capture_in(cap_b), .stat(stat),
        .timer_a_waveform_out(pins[0]), .timer_b_waveform_out(pins[1]),
        .pulse_out_first(pins[2]), .pulse_out_second(pins[3]), .pulse_out_third(pins[4]),
        .pulse_out_fourth(pins[5]), .pulse_out_fifth(pins[6]), .pulse_out_sixth(pins[7]));
    mtpc_pins_model u_pins (.clk(clk), .rst(rst), .run(run), .half(half),
        .cap_a(cap_a), .gate_a(gate_a), .cap_b(cap_b));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task end_of_test();
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    function automatic mtpc_cfg_t mk(mtpc_mode_t m, logic rep, logic [4:0] p, logic [15:0] r);
        mk = '{enable:1'b1, repeat_run:rep, mode:m, prescale:p, out_en:1'b1, irq_rise_en:1'b1,
               irq_fall_en:1'b1, rise_count:r, fall_count:16'h0004, default:'0};
    endfunction : mk
    // Configure first, then pulse start
    task go(input int i, input mtpc_cfg_t v);
        @(posedge clk) cfg[i] <= v;
        @(posedge clk) cfg[i].start <= 1'b1;
        @(posedge clk) cfg[i].start <= 1'b0;
    endtask : go
    task halt(input int i);
        @(posedge clk) cfg[i].stop <= 1'b1;
        @(posedge clk) cfg[i] <= '0;
        repeat (3) @(posedge clk);
        check(stat[i].running, 1'b0);
    endtask : halt
    // Bounded wait for all expected events
    task drain();
        for (int n = 0; n < 400 && exp_q.size() > 0; n++) @(posedge clk);
        watch = 0;
        if (exp_q.size() > 0) begin
            num_errors++;
            end_of_test();
        end
    endtask : drain
    initial forever #5 clk = ~clk;
    // Watch timer 0 events, compare with oldest note
    always @(posedge clk) begin
        cyc++;
        if (cfg[0].start) ref_c = cyc;
        if (watch && (stat[0].rise_event || stat[0].fall_event)) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : -1;
            check(stat[0].fall_event, e[0]);
            if (e > 1) check(cyc - ref_c, e >> 1);
            ref_c = cyc;
        end
    end
    initial begin
        foreach (cfg[i]) cfg[i] = '0;
        run = 1'b0;
        half = 8'h05;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        void'($urandom(58));
        exp_q = '{6, 7};
        watch = 1;
        go(0, mk(MTPC_MODE_TIMER, 1'b0, 5'h00, 16'h0002));
        drain();
        repeat (3) @(posedge clk);
        check(stat[0].running, 1'b0);
        for (int p = 0; p < 3; p++) begin
            exp_q = '{0, (3 << p) * 2 + 1, (2 << p) * 2, (3 << p) * 2 + 1};
            watch = 1;
            go(0, mk(MTPC_MODE_TIMER, 1'b1, p[4:0], 16'h0002));
            drain();
            halt(0);
        end
        // Every other timer: refused modes from timer 2 up, then a repeat pulse on its pin (index 8 has none)
        for (int i = 1; i < 9; i++) begin
            for (int m = 1; m < 3 && i > 1; m++) begin
                go(i, mk(mtpc_mode_t'(m), 1'b1, 5'h00, 16'h0002));
                repeat (3) @(posedge clk);
                check(stat[i].running, 1'b0);
            end
            c = mk(MTPC_MODE_TIMER, 1'b1, 5'h00, 16'h0002);
            c.invert = i[0];
            go(i, c);
            repeat (3) @(posedge clk);
            check(stat[i].running, 1'b1);
            h = 0;
            repeat (20) @(posedge clk) h += (i < 8) ? pins[i[2:0]] : 1'b0;
            check(h, (i > 7) ? 0 : (i[0] ? 8 : 12));
            halt(i);
        end
        for (int be = 0; be < 2; be++) begin
            c = mk(MTPC_MODE_COUNTER, 1'b1, 5'h00, 16'h0002);
            c.irq_rise_en = 1'b0;
            c.both_edges = be[0];
            c.fall_count = 16'h00ff;
            k = $urandom % 6 + 1;
            go(0, c);
            @(posedge clk) run <= 1'b1;
            repeat (2 * k * 5) @(posedge clk);
            run <= 1'b0;
            repeat (6) @(posedge clk);
            check(stat[0].count, k << be);
            halt(0);
        end
        half = 8'h05 + 8'($urandom % 4);
        go(1, mk(MTPC_MODE_CAPTURE, 1'b1, 5'h00, 16'h0002));
        @(posedge clk) run <= 1'b1;
        repeat (2 * half + 4) @(posedge clk);
        r1 = stat[1].cap_rise;
        f1 = stat[1].cap_fall;
        repeat (2 * half) @(posedge clk);
        check(16'(stat[1].cap_rise - r1), 16'(2 * half));
        check(16'(f1 - r1), 16'(half));
        run <= 1'b0;
        halt(1);
        // Half-scale value: NRZ about one in two, RETURN_ZERO_ENCODING one in four
        for (int rt = 0; rt < 2; rt++) begin
            c = mk(MTPC_MODE_DSIGMA, 1'b1, 5'h00, 16'h8000);
            c.return_zero_encoding = rt[0];
            h = 0;
            go(2, c);
            repeat (1024) @(posedge clk) h += pins[2];
            check(h >= (512 >> rt) - 1 && h <= (512 >> rt) + 1, 1'b1);
            halt(2);
        end
        // Reset in mid-run clears a running timer and its pin
        go(3, mk(MTPC_MODE_TIMER, 1'b1, 5'h00, 16'h0002));
        repeat (4) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        check(stat[3].running, 1'b0);
        check(pins[3], 1'b0);
        rst <= 1'b0;
        halt(3);
        end_of_test();
    end
    // Cut a hang short
    initial begin
        repeat (90000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
endmodule : mtpc_top_tb_top
bind mtpc_top mtpc_top_assertions u_chk (.clk(clk), .rst(rst), .cfg(cfg), .stat(stat),
    .timer_a_waveform_out(timer_a_waveform_out));
`default_nettype wire

// ### verilog/mtpc_channel.sv
// Purpose: one timer channel of the multimode block
// Assumes: synchronous inputs, one clock
// Notes: external-input modes gated by HAS_EXT
`timescale 1ns/1ps
`default_nettype none
`include "mtpc_map.svh"
module mtpc_channel
    import mtpc_pkg::*;
#(
    parameter bit HAS_EXT = 1'b0,
    parameter bit HAS_OUT = 1'b1
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire mtpc_cfg_t  cfg,
    input  wire logic       ext_in,
    output mtpc_stat_t      stat,
    output logic            wave_out
);
    // Run state, one-hot
    typedef enum logic [2:0] {
        MTPC_ST_IDLE = 3'b001,
        MTPC_ST_RUN  = 3'b010,
        MTPC_ST_DONE = 3'b100
    } mtpc_state_t;

    mtpc_state_t                   state;    // Run state
    logic [`MTPC_PRE_CNT_W-1:0]    pre_cnt;  // Prescale divider
    logic                          tick;     // Timer clock tick
    logic [`MTPC_CNT_W-1:0]        cnt;      // Main counter
    logic                          wave;     // Raw waveform
    logic                          ext_d;    // Last external level
    logic                          ext_rise; // External rising edge
    logic                          ext_fall; // External falling edge
    logic [`MTPC_DS_W-1:0]         ds_acc;   // Delta-sigma accumulator
    logic [`MTPC_DS_W:0]           ds_sum;   // Accumulator plus value
    logic                          ds_bit;   // Delta-sigma output bit
    logic                          rz_phase; // RETURN_ZERO_ENCODING return phase
    logic                          mode_ok;  // Mode allowed here
    logic                          cnt_mode; // Counter mode active
    logic                          running;  // Running mirror
    logic                          rise_ev;  // Rise event pulse
    logic                          fall_ev;  // Fall event pulse
    logic [`MTPC_CNT_W-1:0]        cnt_seen; // Counter mirror
    logic [`MTPC_CNT_W-1:0]        cap_rise; // Stamp at input rise
    logic [`MTPC_CNT_W-1:0]        cap_fall; // Stamp at input fall

    // Mode capability filter
    always_comb begin
        mode_ok = 1'b1;
        if (!HAS_EXT && (cfg.mode == MTPC_MODE_COUNTER || cfg.mode == MTPC_MODE_CAPTURE)) begin
            mode_ok = 1'b0;
        end
    end
    assign cnt_mode = (cfg.mode == MTPC_MODE_COUNTER);

    // Prescale tick: divide by 2**prescale, and by 2**17 for any prescale above 16
    always_comb begin
        if (cfg.prescale == '0) begin
            tick = 1'b1;
        end else begin
            tick = (pre_cnt == ((`MTPC_PRE_CNT_W'(1) << cfg.prescale) - `MTPC_PRE_CNT_W'(1)));
        end
    end

    always_ff @(posedge clk) begin
        if (rst || state != MTPC_ST_RUN || tick) begin
            pre_cnt <= '0;
        end else begin
            pre_cnt <= pre_cnt + `MTPC_PRE_CNT_W'(1);
        end
    end

    // External edge detect
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_d <= 1'b0;
        end else begin
            ext_d <= ext_in;
        end
    end
    assign ext_rise = ext_in && !ext_d;
    assign ext_fall = !ext_in && ext_d;

    // Run control state machine
    always_ff @(posedge clk) begin
        if (rst || !cfg.enable || cfg.stop) begin
            state <= MTPC_ST_IDLE;
        end else begin
            case (state)
                MTPC_ST_IDLE: begin
                    if (cfg.start && mode_ok) begin
                        state <= MTPC_ST_RUN;
                    end
                end
                MTPC_ST_RUN: begin
                    if (cfg.start) begin
                        state <= MTPC_ST_RUN;
                    end else if ((cfg.mode == MTPC_MODE_TIMER || cnt_mode) && tick
                                 && cnt == cfg.fall_count && !cfg.repeat_run) begin
                        state <= MTPC_ST_DONE;
                    end
                end
                MTPC_ST_DONE: begin
                    if (cfg.start) begin
                        state <= MTPC_ST_RUN;
                    end
                end
                default: state <= MTPC_ST_IDLE;
            endcase
        end
    end

    // Counter, waveform and edge events
    always_ff @(posedge clk) begin
        rise_ev <= 1'b0;
        fall_ev <= 1'b0;
        if (rst || cfg.start || state != MTPC_ST_RUN) begin
            cnt  <= '0;
            wave <= 1'b0;
        end else if (cfg.mode == MTPC_MODE_TIMER || cnt_mode) begin
            if (cnt_mode ? (ext_rise || (cfg.both_edges && ext_fall)) : tick) begin
                if (cnt == cfg.fall_count) begin
                    cnt  <= '0;
                    wave <= 1'b0;
                    fall_ev <= cfg.irq_fall_en;
                end else begin
                    cnt <= cnt + `MTPC_CNT_W'(1);
                    if (cnt + `MTPC_CNT_W'(1) == cfg.rise_count) begin
                        wave <= 1'b1;
                        rise_ev <= cfg.irq_rise_en;
                    end
                end
            end
        end else if (cfg.mode == MTPC_MODE_CAPTURE) begin
            if (tick) begin
                cnt <= cnt + `MTPC_CNT_W'(1);
            end
        end
    end

    // Capture stamps, visible while running
    always_ff @(posedge clk) begin
        if (rst || (cfg.start && state != MTPC_ST_RUN)) begin
            cap_rise <= '0;
            cap_fall <= '0;
        end else if (state == MTPC_ST_RUN && cfg.mode == MTPC_MODE_CAPTURE && tick) begin
            if (ext_rise) begin
                cap_rise <= cnt;
            end
            if (ext_fall) begin
                cap_fall <= cnt;
            end
        end
    end

    // Delta-sigma first-order modulator
    assign ds_sum = {1'b0, ds_acc} + {2'b00, cfg.rise_count};
    always_ff @(posedge clk) begin
        if (rst || state != MTPC_ST_RUN || cfg.mode != MTPC_MODE_DSIGMA) begin
            ds_acc   <= '0;
            ds_bit   <= 1'b0;
            rz_phase <= 1'b0;
        end else if (tick) begin
            rz_phase <= cfg.return_zero_encoding ? !rz_phase : 1'b0;
            if (!rz_phase) begin
                ds_acc <= {1'b0, ds_sum[`MTPC_CNT_W-1:0]};
                ds_bit <= ds_sum[`MTPC_CNT_W];
            end else begin
                ds_bit <= 1'b0;
            end
        end
    end

    // Pin output register
    always_ff @(posedge clk) begin
        if (rst || !HAS_OUT || !cfg.out_en) begin
            wave_out <= 1'b0;
        end else if (cfg.mode == MTPC_MODE_DSIGMA) begin
            wave_out <= ds_bit ^ cfg.invert;
        end else begin
            wave_out <= wave ^ cfg.invert;
        end
    end

    // Status mirrors
    always_ff @(posedge clk) begin
        if (rst) begin
            running  <= 1'b0;
            cnt_seen <= '0;
        end else begin
            running  <= (state == MTPC_ST_RUN);
            cnt_seen <= cnt;
        end
    end

    // One driver for the status word, every field registered
    assign stat = '{running: running, rise_event: rise_ev, fall_event: fall_ev,
                    count: cnt_seen, cap_rise: cap_rise, cap_fall: cap_fall};
endmodule : mtpc_channel
`default_nettype wire

// ### verilog/mtpc_map.svh
// Purpose: constants for the multimode timer block
// Assumes: 100 MHz clock, synchronous active-high reset
// Notes: all offsets, widths and counts live here as macros
`ifndef MTPC_MAP_SVH
`define MTPC_MAP_SVH
`define MTPC_NUM_TIMERS   9
`define MTPC_CNT_W        16
`define MTPC_PRE_W        5
`define MTPC_PRE_MAX      5'h10
`define MTPC_PRE_CNT_W    17
`define MTPC_DS_W         17
`define MTPC_FULL_IDX     2
`endif

// ### verilog/mtpc_pkg.sv
// Purpose: shared types for the multimode timer block
// Assumes: included map header for widths
// Notes: modes are binary coded
`include "mtpc_map.svh"
package mtpc_pkg;
    // Operating mode request
    typedef enum logic [2:0] {
        MTPC_MODE_TIMER   = 3'h0,
        MTPC_MODE_COUNTER = 3'h1,
        MTPC_MODE_CAPTURE = 3'h2,
        MTPC_MODE_DSIGMA  = 3'h3
    } mtpc_mode_t;
    // Per-timer configuration
    typedef struct packed {
        logic                     enable;      // Timer powered
        logic                     start;       // Start pulse
        logic                     stop;        // Stop pulse
        logic                     repeat_run;  // Repeat form
        mtpc_mode_t               mode;        // Mode select
        logic [`MTPC_PRE_W-1:0]   prescale;    // Clock exponent
        logic                     out_en;      // Drive pin
        logic                     invert;      // Invert output
        logic                     irq_rise_en; // Rise event enable
        logic                     irq_fall_en; // Fall event enable
        logic                     both_edges;  // Counter both edges
        logic                     return_zero_encoding;         // return_zero_encoding
        logic [`MTPC_CNT_W-1:0]   rise_count;  // Time to rise
        logic [`MTPC_CNT_W-1:0]   fall_count;  // Time to fall
    } mtpc_cfg_t;
    // Per-timer status
    typedef struct packed {
        logic                     running;    // Timer active
        logic                     rise_event; // Rise event pulse
        logic                     fall_event; // Fall event pulse
        logic [`MTPC_CNT_W-1:0]   count;      // Live counter
        logic [`MTPC_CNT_W-1:0]   cap_rise;   // Capture rise stamp
        logic [`MTPC_CNT_W-1:0]   cap_fall;   // Capture fall stamp
    } mtpc_stat_t;
endpackage : mtpc_pkg

// ### verilog/mtpc_top.sv
// Purpose: nine-timer block with PWM, counter, capture, delta-sigma
// Assumes: pins routed by software before enable
// Notes: timers 0 and 1 have external inputs; index 8 has no pin
`timescale 1ns/1ps
`default_nettype none
`include "mtpc_map.svh"
module mtpc_top
    import mtpc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire mtpc_cfg_t  cfg [`MTPC_NUM_TIMERS],
    input  wire logic       timer_a_capture_in,
    input  wire logic       timer_a_clock_gate_in,
    input  wire logic       timer_b_capture_in,
    output mtpc_stat_t      stat [`MTPC_NUM_TIMERS],
    output logic            timer_a_waveform_out,
    output logic            timer_b_waveform_out,
    output logic            pulse_out_first,
    output logic            pulse_out_second,
    output logic            pulse_out_third,
    output logic            pulse_out_fourth,
    output logic            pulse_out_fifth,
    output logic            pulse_out_sixth
);
    logic [`MTPC_NUM_TIMERS-1:0] wave; // Channel pin drives
    logic [`MTPC_NUM_TIMERS-1:0] ext;  // Channel external inputs

    // Timer a counts clock gate, captures capture pin
    assign ext[0] = (cfg[0].mode == MTPC_MODE_COUNTER) ? timer_a_clock_gate_in
                                                       : timer_a_capture_in;
    assign ext[1] = timer_b_capture_in;
    assign ext[`MTPC_NUM_TIMERS-1:2] = '0;

    // One channel per timer index
    for (genvar i = 0; i < `MTPC_NUM_TIMERS; i++) begin : g_tim
        mtpc_channel #(
            .HAS_EXT (i < 2),
            .HAS_OUT (i < `MTPC_NUM_TIMERS - 1)
        ) u_ch (
            .clk      (clk),
            .rst      (rst),
            .cfg      (cfg[i]),
            .ext_in   (ext[i]),
            .stat     (stat[i]),
            .wave_out (wave[i])
        );
    end

    // Pin map, outputs already registered in channels
    assign timer_a_waveform_out = wave[0];
    assign timer_b_waveform_out = wave[1];
    assign pulse_out_first      = wave[2];
    assign pulse_out_second     = wave[3];
    assign pulse_out_third      = wave[4];
    assign pulse_out_fourth     = wave[5];
    assign pulse_out_fifth      = wave[6];
    assign pulse_out_sixth      = wave[7];
endmodule : mtpc_top
`default_nettype wire
